// File: logic/iec958_tx_pkg.sv
// Function
// - Serial output is biphase mark with audio, channel status and user bits.
// - Output stream changes on both edges of the transmit clock.
// - Transmit clock comes from an internal generator on externally supplied clock.
// - Channel status bits 0 to 47 come from host-written channel status registers; frames 48 to 191 send zero.
// - Left and right samples are held in separate sixteen-entry FIFOs.
// - Both FIFOs empty while transmit is enabled, with empty event enabled, raises the empty event.
// - No sample written within one 20.8 us sample period raises underrun.
// - Auto resync copies left fill pointer into right when misaligned, raises event.
// - 16 and 24 bit samples; 24 bit uses only the low 24 bits.
// - Sample rates 32, 44.1 and 48 kHz with two channels.
package iec958_tx_pkg;
    // System clock and frame timing
    localparam longint CLK_HZ = 250_000_000;
    localparam int CLK_MHZ = 250;
    localparam longint FS_32K = 32_000;
    localparam longint FS_44K1 = 44_100;
    localparam longint FS_48K = 48_000;
    localparam longint HALF_CELLS_PER_FRAME = 128;
    localparam logic [31:0] INC_32K = 32'(((FS_32K * HALF_CELLS_PER_FRAME) << 32) / CLK_HZ);
    localparam logic [31:0] INC_44K1 = 32'(((FS_44K1 * HALF_CELLS_PER_FRAME) << 32) / CLK_HZ);
    localparam logic [31:0] INC_48K = 32'(((FS_48K * HALF_CELLS_PER_FRAME) << 32) / CLK_HZ);
    // Underrun window, one sample period at 48 kHz
    localparam int UNDERRUN_NS = 20_800;
    localparam int UNDERRUN_CYCLES = UNDERRUN_NS * CLK_MHZ / 1000;
    // Subframe layout
    localparam logic [5:0] HC_LAST = 6'h3F;
    localparam logic [5:0] HC_DATA = 6'h08;
    localparam logic [7:0] FRAME_LAST = 8'hBF;
    localparam int CS_BITS = 48;
    localparam logic [7:0] PRE_B = 8'hE8;
    localparam logic [7:0] PRE_M = 8'hE2;
    localparam logic [7:0] PRE_W = 8'hE4;
    localparam int FIFO_DEPTH = 16;
    localparam int SAMPLE_W = 24;
    // Register byte offsets
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_EV_EN = 6'h04;
    localparam logic [5:0] REG_EV_STAT = 6'h08;
    localparam logic [5:0] REG_TX_LEFT = 6'h0C;
    localparam logic [5:0] REG_TX_RIGHT = 6'h10;
    localparam logic [5:0] REG_CS_LO = 6'h14;
    localparam logic [5:0] REG_CS_HI = 6'h18;
    localparam logic [5:0] REG_FILL = 6'h1C;
    // Control fields
    localparam int CTRL_TX_EN = 0;
    localparam int CTRL_W24 = 1;
    localparam int CTRL_RESYNC = 2;
    localparam int CTRL_RATE_LSB = 3;
    localparam int CTRL_USER = 5;
    localparam int CTRL_DMA_EN = 6;
    localparam int CTRL_W = 7;
    localparam logic [1:0] RATE_44K1 = 2'h0;
    localparam logic [1:0] RATE_48K = 2'h1;
    localparam logic [1:0] RATE_32K = 2'h2;
    // Event bits
    localparam int EV_EMPTY = 0;
    localparam int EV_UNDERRUN = 1;
    localparam int EV_OVERRUN = 2;
    localparam int EV_RESYNC = 3;
    localparam int EV_W = 4;
    localparam int FILL_R_LSB = 8;
    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
    localparam logic [EV_W-1:0] EV_RST = 4'h0;
    localparam logic [31:0] CS_RST = 32'h0000_0000;
endpackage

// File: logic/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] pop_data,
    output logic full,
    output logic empty,
    output logic [$clog2(DEPTH):0] level,
    output logic [$clog2(DEPTH):0] wr_ptr,
    input wire logic load_wr,
    input wire logic [$clog2(DEPTH):0] load_val
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0] wr_ptr_ff;
    logic [PW:0] rd_ptr_ff;

    ////////////////////////////////////////////////////////////////////////
    // Storage; a push into a full buffer is dropped
    always_ff @(posedge clk) begin
        if (push && !full) begin
            mem[wr_ptr_ff[PW-1:0]] <= push_data;
        end
    end

    // Fill pointer, may be overwritten by a realignment
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_ptr_ff <= '0;
        end else if (load_wr) begin
            wr_ptr_ff <= load_val;
        end else if (push && !full) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
        end
    end

    // Drain pointer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_ptr_ff <= '0;
        end else if (pop && !empty) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end

    // Extra pointer bit tells full from empty
    assign level = wr_ptr_ff - rd_ptr_ff;
    assign full = (level == (PW+1)'(DEPTH));
    assign empty = (level == '0);
    assign wr_ptr = wr_ptr_ff;
    assign pop_data = mem[rd_ptr_ff[PW-1:0]];

    ////////////////////////////////////////////////////////////////////////
    property p_depth_bound;
        @(posedge clk) disable iff (!resetn) level <= (PW+1)'(DEPTH);
    endproperty
    a_depth_bound: assert property (p_depth_bound) else $error("fifo level above depth");
endmodule

// File: logic/iec958_transmitter.sv
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module iec958_transmitter #(
    parameter int DEPTH = iec958_tx_pkg::FIFO_DEPTH,
    parameter int UNDERRUN_CYCLES = iec958_tx_pkg::UNDERRUN_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic audio_out,
    output logic tx_clk,
    output logic dma_req,
    output logic event_irq
);
    localparam int PW = $clog2(DEPTH);
    localparam int SW = iec958_tx_pkg::SAMPLE_W;

    // Bus state
    logic waitrequest_ff;
    logic [31:0] readdata_ff;
    logic [31:0] nxt_readdata;
    logic wr_acc;
    // Software registers
    logic [iec958_tx_pkg::CTRL_W-1:0] ctrl_ff;
    logic [iec958_tx_pkg::EV_W-1:0] ev_en_ff;
    logic [iec958_tx_pkg::EV_W-1:0] ev_stat_ff;
    logic [31:0] cs_lo_ff;
    logic [31:0] cs_hi_ff;
    logic tx_en;
    logic w24;
    // Buffers
    logic push_l, push_r, pop;
    logic [SW-1:0] pop_l, pop_r;
    logic full_l, full_r, empty_l, empty_r;
    logic [PW:0] lvl_l, lvl_r, wptr_l;
    logic resync;
    // Clock generator
    logic [31:0] acc_ff;
    logic [31:0] inc;
    logic [32:0] acc_sum;
    logic tick;
    // Serialiser
    logic [5:0] hc_ff;
    logic right_ff;
    logic [7:0] frame_ff;
    logic [31:0] sf_ff;
    logic [SW-1:0] rsamp_ff;
    logic rvalid_ff;
    logic pol_ff;
    logic pol;
    logic audio_out_ff;
    logic tx_clk_ff;
    logic nxt_level;
    logic [7:0] pre;
    logic cs_bit;
    logic [iec958_tx_pkg::CS_BITS-1:0] cs_all;
    logic frame_start;
    // Events
    logic [iec958_tx_pkg::EV_W-1:0] ev_set;
    logic [31:0] und_cnt_ff;
    logic und_hit;
    logic dma_req_ff;
    logic event_irq_ff;

    // Build one subframe word: aux, audio, V, U, C, even parity
    function automatic logic [31:0] build_sf(input logic [SW-1:0] s, input logic wide,
                                             input logic valid, input logic u, input logic c);
        logic [31:0] w;
        w = '0;
        w[27:4] = wide ? s : {s[15:0], 8'h00};
        w[28] = !valid;
        w[29] = u;
        w[30] = c;
        w[31] = ^w[30:4];
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: waitrequest drops one cycle after a request appears
    assign wr_acc = write && !waitrequest_ff;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            waitrequest_ff <= 1'b1;
        end else if ((read || write) && waitrequest_ff) begin
            waitrequest_ff <= 1'b0;
        end else begin
            waitrequest_ff <= 1'b1;
        end
    end

    // Read data is registered on the same edge that waitrequest falls
    always_ff @(posedge clk) begin
        if (!resetn) begin
            readdata_ff <= '0;
        end else if (read && waitrequest_ff) begin
            readdata_ff <= nxt_readdata;
        end
    end

    // Read decode; sample registers and unmapped offsets read zero
    always_comb begin
        nxt_readdata = '0;
        if (address == iec958_tx_pkg::REG_CTRL) begin
            nxt_readdata[iec958_tx_pkg::CTRL_W-1:0] = ctrl_ff;
        end else if (address == iec958_tx_pkg::REG_EV_EN) begin
            nxt_readdata[iec958_tx_pkg::EV_W-1:0] = ev_en_ff;
        end else if (address == iec958_tx_pkg::REG_EV_STAT) begin
            nxt_readdata[iec958_tx_pkg::EV_W-1:0] = ev_stat_ff;
        end else if (address == iec958_tx_pkg::REG_CS_LO) begin
            nxt_readdata = cs_lo_ff;
        end else if (address == iec958_tx_pkg::REG_CS_HI) begin
            nxt_readdata[15:0] = cs_hi_ff[15:0];
        end else if (address == iec958_tx_pkg::REG_FILL) begin
            nxt_readdata[PW:0] = lvl_l;
            nxt_readdata[iec958_tx_pkg::FILL_R_LSB +: PW+1] = lvl_r;
        end
    end

    // Control and event enable registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_ff <= iec958_tx_pkg::CTRL_RST;
            ev_en_ff <= iec958_tx_pkg::EV_RST;
        end else if (wr_acc && address == iec958_tx_pkg::REG_CTRL) begin
            ctrl_ff <= writedata[iec958_tx_pkg::CTRL_W-1:0];
        end else if (wr_acc && address == iec958_tx_pkg::REG_EV_EN) begin
            ev_en_ff <= writedata[iec958_tx_pkg::EV_W-1:0];
        end
    end

    // Channel status words; host keeps them fixed while playing
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cs_lo_ff <= iec958_tx_pkg::CS_RST;
            cs_hi_ff <= iec958_tx_pkg::CS_RST;
        end else if (wr_acc && address == iec958_tx_pkg::REG_CS_LO) begin
            cs_lo_ff <= writedata;
        end else if (wr_acc && address == iec958_tx_pkg::REG_CS_HI) begin
            cs_hi_ff <= {16'h0000, writedata[15:0]};
        end
    end

    assign tx_en = ctrl_ff[iec958_tx_pkg::CTRL_TX_EN];
    assign w24 = ctrl_ff[iec958_tx_pkg::CTRL_W24];

    ////////////////////////////////////////////////////////////////////////
    // Sample buffers, one per channel
    assign push_l = wr_acc && address == iec958_tx_pkg::REG_TX_LEFT;
    assign push_r = wr_acc && address == iec958_tx_pkg::REG_TX_RIGHT;

    sample_fifo #(.WIDTH(SW), .DEPTH(DEPTH)) left_fifo (
        .clk(clk),
        .resetn(resetn),
        .push(push_l),
        .push_data(writedata[SW-1:0]),
        .pop(pop),
        .pop_data(pop_l),
        .full(full_l),
        .empty(empty_l),
        .level(lvl_l),
        .wr_ptr(wptr_l),
        .load_wr(1'b0),
        .load_val('0)
    );

    sample_fifo #(.WIDTH(SW), .DEPTH(DEPTH)) right_fifo (
        .clk(clk),
        .resetn(resetn),
        .push(push_r),
        .push_data(writedata[SW-1:0]),
        .pop(pop),
        .pop_data(pop_r),
        .full(full_r),
        .empty(empty_r),
        .level(lvl_r),
        .wr_ptr(),
        .load_wr(resync),
        .load_val(wptr_l + (PW+1)'(push_l && !full_l)) // A left write in the same cycle counts too
    );

    // Pairs are checked at each frame start; a right-side write can race a left one,
    // so checking at any other time would realign half-written pairs
    assign frame_start = tick && tx_en && hc_ff == '0 && !right_ff;
    assign resync = frame_start && ctrl_ff[iec958_tx_pkg::CTRL_RESYNC] && lvl_l != lvl_r;
    assign pop = frame_start && !resync && !empty_l && !empty_r;

    ////////////////////////////////////////////////////////////////////////
    // Clock generator: phase accumulator, carry marks a half-cell
    always_comb begin
        if (ctrl_ff[iec958_tx_pkg::CTRL_RATE_LSB +: 2] == iec958_tx_pkg::RATE_48K) begin
            inc = iec958_tx_pkg::INC_48K;
        end else if (ctrl_ff[iec958_tx_pkg::CTRL_RATE_LSB +: 2] == iec958_tx_pkg::RATE_32K) begin
            inc = iec958_tx_pkg::INC_32K;
        end else begin
            inc = iec958_tx_pkg::INC_44K1;
        end
    end

    assign acc_sum = {1'b0, acc_ff} + {1'b0, inc};
    assign tick = acc_sum[32];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            acc_ff <= '0;
        end else begin
            acc_ff <= acc_sum[31:0];
        end
    end

    // Transmit clock toggles every half-cell, one cycle per bit cell
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_clk_ff <= 1'b0;
        end else if (tick) begin
            tx_clk_ff <= !tx_clk_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame position: half-cell, channel, frame in the block
    always_ff @(posedge clk) begin
        if (!resetn || !tx_en) begin
            hc_ff <= '0;
            right_ff <= 1'b0;
            frame_ff <= '0;
        end else if (tick) begin
            hc_ff <= hc_ff + 6'h01;
            if (hc_ff == iec958_tx_pkg::HC_LAST) begin
                right_ff <= !right_ff;
                if (right_ff) begin
                    frame_ff <= (frame_ff == iec958_tx_pkg::FRAME_LAST) ? 8'h00 : frame_ff + 8'h01;
                end
            end
        end
    end

    // status bit of this frame from the status registers
    assign cs_all = {cs_hi_ff[15:0], cs_lo_ff};
    assign cs_bit = (frame_ff < 8'(iec958_tx_pkg::CS_BITS)) ? cs_all[frame_ff[5:0]] : 1'b0;

    // Subframe words; an empty pair sends silence flagged invalid
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sf_ff <= '0;
            rsamp_ff <= '0;
            rvalid_ff <= 1'b0;
        end else if (tick && tx_en && hc_ff == '0) begin
            if (!right_ff) begin
                sf_ff <= build_sf(pop ? pop_l : '0, w24, pop, ctrl_ff[iec958_tx_pkg::CTRL_USER], cs_bit);
                rsamp_ff <= pop ? pop_r : '0;
                rvalid_ff <= pop;
            end else begin
                sf_ff <= build_sf(rsamp_ff, w24, rvalid_ff, ctrl_ff[iec958_tx_pkg::CTRL_USER], cs_bit);
            end
        end
    end

    // Preamble reference is the line level just before the subframe
    assign pol = (hc_ff == '0) ? audio_out_ff : pol_ff;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pol_ff <= 1'b0;
        end else if (tick && hc_ff == '0) begin
            pol_ff <= audio_out_ff;
        end
    end

    // Block start, left or right preamble
    always_comb begin
        if (right_ff) begin
            pre = iec958_tx_pkg::PRE_W;
        end else if (frame_ff == '0) begin
            pre = iec958_tx_pkg::PRE_B;
        end else begin
            pre = iec958_tx_pkg::PRE_M;
        end
    end

    // biphase mark: edge at each cell start, mid edge for a one
    always_comb begin
        if (hc_ff < iec958_tx_pkg::HC_DATA) begin
            nxt_level = pre[3'h7 - hc_ff[2:0]] ^ pol;
        end else if (!hc_ff[0]) begin
            nxt_level = !audio_out_ff;
        end else begin
            nxt_level = audio_out_ff ^ sf_ff[hc_ff[5:1]];
        end
    end

    // line moves on transmit clock edges only
    // Disabling parks the line low at the next edge, never between edges
    always_ff @(posedge clk) begin
        if (!resetn) begin
            audio_out_ff <= 1'b0;
        end else if (tick) begin
            audio_out_ff <= tx_en ? nxt_level : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Underrun timer restarts on every sample write
    assign und_hit = tx_en && und_cnt_ff == 32'(UNDERRUN_CYCLES - 1);

    always_ff @(posedge clk) begin
        if (!resetn || !tx_en || push_l || push_r || und_hit) begin
            und_cnt_ff <= '0;
        end else begin
            und_cnt_ff <= und_cnt_ff + 32'h0000_0001;
        end
    end

    // Raw events, each gated by its enable
    always_comb begin
        ev_set = '0;
        ev_set[iec958_tx_pkg::EV_EMPTY] = tx_en && empty_l && empty_r;
        ev_set[iec958_tx_pkg::EV_UNDERRUN] = und_hit;
        ev_set[iec958_tx_pkg::EV_OVERRUN] = (push_l && full_l) || (push_r && full_r);
        ev_set[iec958_tx_pkg::EV_RESYNC] = resync;
        ev_set = ev_set & ev_en_ff;
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ev_stat_ff <= iec958_tx_pkg::EV_RST;
        end else if (wr_acc && address == iec958_tx_pkg::REG_EV_STAT) begin
            ev_stat_ff <= (ev_stat_ff & ~writedata[iec958_tx_pkg::EV_W-1:0]) | ev_set;
        end else begin
            ev_stat_ff <= ev_stat_ff | ev_set;
        end
    end

    // Request and event outputs, registered
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dma_req_ff <= 1'b0;
            event_irq_ff <= 1'b0;
        end else begin
            dma_req_ff <= ctrl_ff[iec958_tx_pkg::CTRL_DMA_EN] && tx_en && !full_l && !full_r;
            event_irq_ff <= |ev_stat_ff;
        end
    end

    assign readdata = readdata_ff;
    assign waitrequest = waitrequest_ff;
    assign audio_out = audio_out_ff;
    assign tx_clk = tx_clk_ff;
    assign dma_req = dma_req_ff;
    assign event_irq = event_irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_cell_edge;
        tick && tx_en && hc_ff >= iec958_tx_pkg::HC_DATA && !hc_ff[0] |=> audio_out_ff != $past(audio_out_ff);
    endproperty
    a_cell_edge: assert property (p_cell_edge) else $error("missing cell start transition");

    property p_both_edges;
        $changed(audio_out_ff) |-> $changed(tx_clk_ff);
    endproperty
    a_both_edges: assert property (p_both_edges) else $error("line moved without clock edge");

    property p_clk_source;
        $changed(tx_clk_ff) |-> $past(tick);
    endproperty
    a_clk_source: assert property (p_clk_source) else $error("transmit clock moved off tick");

    property p_cs_bit;
        tick && tx_en && hc_ff == '0 |=> sf_ff[30] == $past(cs_bit);
    endproperty
    a_cs_bit: assert property (p_cs_bit) else $error("status bit not from register");

    property p_empty_ev;
        tx_en && empty_l && empty_r && ev_en_ff[iec958_tx_pkg::EV_EMPTY] |=> ev_stat_ff[iec958_tx_pkg::EV_EMPTY];
    endproperty
    a_empty_ev: assert property (p_empty_ev) else $error("empty event missed");

    property p_underrun;
        tx_en && und_cnt_ff == 32'(UNDERRUN_CYCLES - 1) && ev_en_ff[iec958_tx_pkg::EV_UNDERRUN]
            |=> ev_stat_ff[iec958_tx_pkg::EV_UNDERRUN] && und_cnt_ff == '0;
    endproperty
    a_underrun: assert property (p_underrun) else $error("underrun not raised on time");

    property p_resync;
        resync |=> lvl_l == lvl_r;
    endproperty
    a_resync: assert property (p_resync) else $error("right buffer not realigned");

    property p_width;
        tick && tx_en && hc_ff == '0 && !right_ff && pop && w24 |=> sf_ff[27:4] == $past(pop_l);
    endproperty
    a_width: assert property (p_width) else $error("24 bit sample misplaced");

    property p_rate;
        ctrl_ff[iec958_tx_pkg::CTRL_RATE_LSB +: 2] == iec958_tx_pkg::RATE_48K |-> inc == iec958_tx_pkg::INC_48K;
    endproperty
    a_rate: assert property (p_rate) else $error("wrong rate increment");

    property p_overrun;
        push_l && full_l && ev_en_ff[iec958_tx_pkg::EV_OVERRUN]
            |=> ev_stat_ff[iec958_tx_pkg::EV_OVERRUN] && lvl_l == $past(lvl_l) - (PW+1)'($past(pop));
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");
endmodule

// File: testbench/spdif_rx_model.sv
`timescale 1ns/1ps
// Far-end receiver: counts half-cells and stray line changes
module spdif_rx_model (
    input wire logic clk,
    input wire logic tx_clk,
    input wire logic audio_out,
    output int cells,
    output int stray
);
    logic last_clk_ff = 1'b0;
    logic last_dat_ff = 1'b0;
    initial begin
        cells = 0;
        stray = 0;
    end
    ////////////////////////////////////////////////////////////
    // line moves with clock
    // A change without a clock edge would smear the biphase cell
    always @(posedge clk) begin
        last_clk_ff <= tx_clk;
        last_dat_ff <= audio_out;
        if (tx_clk !== last_clk_ff) begin
            cells <= cells + 1;
        end else if (audio_out !== last_dat_ff) begin
            stray <= stray + 1;
        end
    end
endmodule

// File: testbench/tb_iec958_transmitter.sv
`timescale 1ns/1ps
module tb_iec958_transmitter;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic [31:0] rd;
    logic waitrequest, audio_out, tx_clk, dma_req, event_irq;
    int err_total = 0;
    int cmp_count = 0;
    int cells, stray;
    ////////////////////////////////////////////////////////////
    // 250 MHz system clock
    always #2 clk = ~clk;
    // Short underrun window keeps the run brief
    iec958_transmitter #(.DEPTH(16), .UNDERRUN_CYCLES(200)) iec958_transmitter_inst (.clk(clk), .resetn(resetn),
        .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .audio_out(audio_out), .tx_clk(tx_clk), .dma_req(dma_req), .event_irq(event_irq));
    spdif_rx_model spdif_rx_model_inst (.clk(clk), .tx_clk(tx_clk), .audio_out(audio_out), .cells(cells), .stray(stray));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask
    // Request held until waitrequest is sampled low
    // Only the watchdog ends a wait that never comes
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask
    task automatic do_reset();
        resetn <= 1'b0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdc(iec958_tx_pkg::REG_CTRL, 32'h0, "ctrl");
        rdc(iec958_tx_pkg::REG_TX_LEFT, 32'h0, "left");
        rdc(6'h20, 32'h0, "unmapped");
        bus(1'b1, iec958_tx_pkg::REG_CS_LO, 32'hA5A5_5A5A);
        rdc(iec958_tx_pkg::REG_CS_LO, 32'hA5A5_5A5A, "cs lo");
        bus(1'b1, iec958_tx_pkg::REG_CS_HI, 32'hFFFF_1234);
        rdc(iec958_tx_pkg::REG_CS_HI, 32'h0000_1234, "cs hi");
        $display("test regs done");
    endtask
    task automatic t_empty();
        bus(1'b1, iec958_tx_pkg::REG_EV_EN, 32'h1);
        bus(1'b1, iec958_tx_pkg::REG_CTRL, 32'h1);
        rdc(iec958_tx_pkg::REG_EV_STAT, 32'h1, "empty");
        chk(event_irq, 32'h1, "irq");
        bus(1'b1, iec958_tx_pkg::REG_CTRL, 32'h0);
        bus(1'b1, iec958_tx_pkg::REG_EV_STAT, 32'h1);
        rdc(iec958_tx_pkg::REG_EV_STAT, 32'h0, "cleared");
        $display("test empty done");
    endtask
    // Seventeenth left write is meant to be refused
    task automatic t_fill();
        bus(1'b1, iec958_tx_pkg::REG_EV_EN, 32'h4);
        for (int i = 0; i < 17; i++) bus(1'b1, iec958_tx_pkg::REG_TX_LEFT, 32'(i));
        rdc(iec958_tx_pkg::REG_FILL, 32'h0000_0010, "left lvl");
        rdc(iec958_tx_pkg::REG_EV_STAT, 32'h4, "overrun");
        for (int i = 0; i < 16; i++) bus(1'b1, iec958_tx_pkg::REG_TX_RIGHT, 32'(i));
        rdc(iec958_tx_pkg::REG_FILL, 32'h0000_1010, "both lvl");
        bus(1'b1, iec958_tx_pkg::REG_EV_STAT, 32'h4);
        bus(1'b1, iec958_tx_pkg::REG_EV_EN, 32'h0);
        $display("test fill done");
    endtask
    // Half-cell count over a fixed span for rate codes 0 to 2
    task automatic t_rates();
        longint fs[3] = '{44100, 48000, 32000};
        longint exp;
        int c0;
        for (int k = 0; k < 3; k++) begin
            c0 = cells;
            // 48 kHz pass sends 24 bit samples
            bus(1'b1, iec958_tx_pkg::REG_CTRL, 32'((k << 3) | 65 | ((k == 1) ? 2 : 0)));
            repeat (6000) @(posedge clk);
            exp = 6000 * fs[k] * 128 / 250000000;
            chk(32'((cells - c0) >= exp - 3 && (cells - c0) <= exp + 3), 32'h1, "rate");
            chk(dma_req, 32'h1, "dma");
            bus(1'b1, iec958_tx_pkg::REG_CTRL, 32'h0);
        end
        chk(stray, 32'h0, "stray");
        bus(1'b0, iec958_tx_pkg::REG_FILL, 32'h0);
        chk(rd[12:8], rd[4:0], "pair pop");
        chk(32'(rd[4:0] < 5'h10), 32'h1, "drained");
        $display("test rates done");
    endtask
    task automatic t_underrun();
        bus(1'b1, iec958_tx_pkg::REG_EV_EN, 32'h2);
        bus(1'b1, iec958_tx_pkg::REG_CTRL, 32'h1);
        bus(1'b1, iec958_tx_pkg::REG_TX_LEFT, 32'h5);
        repeat (100) @(posedge clk);
        rdc(iec958_tx_pkg::REG_EV_STAT, 32'h0, "early");
        repeat (150) @(posedge clk);
        rdc(iec958_tx_pkg::REG_EV_STAT, 32'h2, "underrun");
        bus(1'b1, iec958_tx_pkg::REG_CTRL, 32'h0);
        $display("test underrun done");
    endtask
    // Mid-run reset gives a known misalignment of three to one
    task automatic t_resync();
        int hit;
        hit = 0;
        do_reset();
        for (int i = 0; i < 3; i++) bus(1'b1, iec958_tx_pkg::REG_TX_LEFT, 32'h10 + 32'(i));
        bus(1'b1, iec958_tx_pkg::REG_TX_RIGHT, 32'h20);
        bus(1'b1, iec958_tx_pkg::REG_EV_EN, 32'h8);
        bus(1'b1, iec958_tx_pkg::REG_CTRL, 32'h5);
        for (int i = 0; i < 40 && hit == 0; i++) begin
            repeat (200) @(posedge clk);
            bus(1'b0, iec958_tx_pkg::REG_EV_STAT, 32'h0);
            hit = int'(rd[3] === 1'b1);
        end
        rdc(iec958_tx_pkg::REG_FILL, 32'h0000_0303, "resync lvl");
        chk(32'(hit), 32'h1, "resync ev");
        $display("test resync done");
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        t_regs();
        t_empty();
        t_fill();
        t_rates();
        t_underrun();
        t_resync();
        print_verdict();
    end
    // Watchdog well past the expected span
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        print_verdict();
    end
endmodule
